// [dv/pmc_board.sv]
// board model: resolves each cell pin from device and board drivers
`timescale 1ns/1ns
`default_nettype none

module pmc_board (
  input wire logic [7:0] io_out,
  input wire logic [7:0] io_oe,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] io_in
);
  // board drives only released pins; pins nobody drives float high on pull-ups
  assign io_in = (io_oe & io_out) | (~io_oe & ext_en & ext_val) | (~io_oe & ~ext_en);
endmodule
`default_nettype wire

// [dv/pmc_checker.sv]
// assertion checker for the cell fabric top, bound to its ports
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"

module pmc_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pmc_pkg::pmc_mode_type cfg_mode,
  input wire pmc_pkg::pmc_kind_type [`PMC_NUM_CELLS-1:0] cfg_kind,
  input wire logic clk_pin,
  input wire logic oe_n_pin,
  input wire logic [`PMC_NUM_CELLS-1:0] io_out,
  input wire logic [`PMC_NUM_CELLS-1:0] io_oe,
  input wire logic [`PMC_NUM_CELLS-1:0] reg_state,
  input wire logic por_done
);
  localparam int POR = `PMC_POR_CYCLES;
  logic clk_q_ff;
  logic [5:0] cnt_ff;
  logic [7:0] regm;
  logic [7:0] inm;
  logic [7:0] simp;
  logic take;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ****************************************
  // helper logic
  // ****************************************
  // cell masks: registered cells, undriven inputs, simple-mode drivers
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      regm[c] = cfg_mode == pmc_pkg::MODE_REGISTERED && cfg_kind[c] == pmc_pkg::KIND_REG;
      inm[c] = cfg_kind[c] == pmc_pkg::KIND_INPUT
        && !(cfg_mode == pmc_pkg::MODE_COMPLEX && (c == 0 || c == 7))
        && !(cfg_mode == pmc_pkg::MODE_SIMPLE && (c == 3 || c == 4));
      simp[c] = c == 3 || c == 4 || cfg_kind[c] != pmc_pkg::KIND_INPUT;
    end
  end
  assign take = clk_pin & ~clk_q_ff & por_done & (cfg_mode == pmc_pkg::MODE_REGISTERED);
  // previous clock pin sample and cycles since reset release
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_q_ff <= 1'b0;
      cnt_ff <= 6'h00;
    end else begin
      clk_q_ff <= clk_pin;
      if (cnt_ff != 6'h3F) begin
        cnt_ff <= cnt_ff + 6'h01;
      end
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  a_refused_rise: assert property (!take |=> $stable(reg_state))
    else $error("register state moved without a counted clock pin rise");
  a_out_inverted: assert property ((io_out & regm) == (~reg_state & regm))
    else $error("registered pin does not show the inverted register");
  a_reg_oe_pin: assert property ((io_oe & regm) == ({8{~oe_n_pin}} & regm))
    else $error("registered pin enable does not follow the enable pin");
  a_input_undriven: assert property ((io_oe & inm) == 8'h00)
    else $error("input cell drives its pin");
  a_simple_oe: assert property (cfg_mode == pmc_pkg::MODE_SIMPLE |-> (io_oe & simp) == simp)
    else $error("simple mode output cell not driving");
  a_por_delay: assert property (por_done == (cnt_ff >= POR))
    else $error("power-up delay length wrong");
  a_reset_clear: assert property ($rose(arst_n) |-> reg_state == 8'h00 && !por_done)
    else $error("registers not cleared by reset");
  a_por_hold: assert property (por_done |=> por_done)
    else $error("power-up done dropped without reset");
  c_capture: cover property (take && regm != 8'h00);
  c_complex: cover property (cfg_mode == pmc_pkg::MODE_COMPLEX && io_oe != 8'h00);
  c_simple_in: cover property (cfg_mode == pmc_pkg::MODE_SIMPLE && io_oe != 8'hFF);
endmodule

bind pmc_top pmc_checker u_chk (.clk_sys, .arst_n, .cfg_mode, .cfg_kind, .clk_pin, .oe_n_pin,
  .io_out, .io_oe, .reg_state, .por_done);
`default_nettype wire

// [dv/tb_top.sv]
// self-checking testbench for the cell fabric top
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  typedef struct {
    logic [1:0] md;
    logic [15:0] kd;
    logic [7:0] inp;
    logic ck;
    logic oen;
    logic [7:0] een;
    logic [7:0] evl;
    logic [7:0] eoe;
    logic [7:0] eout;
  } pmc_row_type;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  pmc_pkg::pmc_mode_type cfg_mode;
  pmc_pkg::pmc_kind_type [7:0] cfg_kind;
  logic [7:0] cfg_polarity = 8'h00;
  logic [63:0] cfg_pt_en;
  logic [63:0][31:0] cfg_and_fuse;
  logic clk_pin = 1'b0;
  logic oe_n_pin = 1'b0;
  logic [7:0] in_pin = 8'h00;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  wire logic [7:0] io_in;
  logic [7:0] io_out;
  logic [7:0] io_oe;
  logic [7:0] reg_state;
  logic por_done;
  logic [7:0] n;
  int err_total = 0;
  int check_count = 0;
  // comb-only cases use simple, complex or registered mode, as a tool would pick
  pmc_row_type rows [6] = '{
    '{2'h2, 16'h5555, 8'h01, 1'h1, 1'h0, 8'h00, 8'h00, 8'hFF, 8'h53},
    '{2'h2, 16'h5555, 8'h00, 1'h0, 1'h1, 8'h00, 8'h00, 8'hFF, 8'h20},
    '{2'h2, 16'h55A9, 8'h00, 1'h0, 1'h0, 8'h06, 8'h02, 8'hF9, 8'h40},
    '{2'h1, 16'h5555, 8'h0F, 1'h1, 1'h1, 8'h00, 8'h00, 8'hF0, 8'h60},
    '{2'h1, 16'h5556, 8'hF0, 1'h1, 1'h0, 8'h00, 8'h00, 8'h0F, 8'h02},
    '{2'h0, 16'h5595, 8'h21, 1'h0, 1'h1, 8'h00, 8'h00, 8'h12, 8'h02}};

  pmc_top u_dut (.clk_sys(clk_sys), .arst_n(arst_n), .cfg_mode(cfg_mode), .cfg_kind(cfg_kind),
    .cfg_polarity(cfg_polarity), .cfg_pt_en(cfg_pt_en), .cfg_and_fuse(cfg_and_fuse),
    .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .in_pin(in_pin), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .reg_state(reg_state), .por_done(por_done));
  pmc_board u_board (.io_out(io_out), .io_oe(io_oe), .ext_en(ext_en), .ext_val(ext_val),
    .io_in(io_in));

  // ****************************************
  // clock, tasks and watchdog
  // ****************************************
  always #10 clk_sys = ~clk_sys;

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic set_cfg(input logic [1:0] md, input logic [15:0] kd);
    cfg_mode <= pmc_pkg::pmc_mode_type'(md);
    for (int c = 0; c < 8; c++) begin
      cfg_kind[c] <= pmc_pkg::pmc_kind_type'(kd[2*c+:2]);
    end
  endtask

  // one clock pin pulse; the register takes it at the second edge
  task automatic pulse(input logic [7:0] v);
    @(posedge clk_sys);
    clk_pin <= 1'b1;
    in_pin <= v;
    @(posedge clk_sys);
    clk_pin <= 1'b0;
    #1;
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #(20 * 5000);
    err_total++;
    test_done();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    cfg_mode = pmc_pkg::MODE_SIMPLE;
    foreach (cfg_kind[k]) begin
      cfg_kind[k] = pmc_pkg::KIND_REG;
    end
    cfg_pt_en = '0;
    cfg_and_fuse = '0;
    // term 0 reads input c+4, term 1 reads input c
    for (int c = 0; c < 8; c++) begin
      cfg_pt_en[8*c] = 1'b1;
      cfg_and_fuse[8*c][(c+4)%8] = 1'b1;
      cfg_pt_en[8*c+1] = 1'b1;
      cfg_and_fuse[8*c+1][c] = 1'b1;
    end
    // feedback terms on slots 0, 2 and 7
    cfg_pt_en[10] = 1'b1;
    cfg_and_fuse[10][8] = 1'b1;
    cfg_pt_en[50] = 1'b1;
    cfg_and_fuse[50][10] = 1'b1;
    cfg_pt_en[42] = 1'b1;
    cfg_and_fuse[42][15] = 1'b1;
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    foreach (rows[i]) begin
      @(posedge clk_sys);
      set_cfg(rows[i].md, rows[i].kd);
      in_pin <= rows[i].inp;
      clk_pin <= rows[i].ck;
      oe_n_pin <= rows[i].oen;
      ext_en <= rows[i].een;
      ext_val <= rows[i].evl;
      @(posedge clk_sys);
      #1;
      chk("pin enable", rows[i].eoe, io_oe);
      chk("pin value", rows[i].eout, io_out & rows[i].eoe);
    end
    // registers in use, so registered mode
    @(posedge clk_sys);
    set_cfg(2'h0, 16'h0000);
    clk_pin <= 1'b0;
    oe_n_pin <= 1'b0;
    in_pin <= 8'hFF;
    ext_en <= 8'h00;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1;
    chk("reset registers", 8'h00, reg_state);
    chk("reset pins", 8'hFF, io_out);
    chk("reset done flag", 8'h00, {7'h00, por_done});
    @(posedge clk_sys);
    arst_n <= 1'b1;
    n = 8'h00;
    // clock pin rise during the power-up delay must be ignored
    while (por_done !== 1'b1 && n < 8'hC8) begin
      @(posedge clk_sys);
      n = n + 8'h01;
      clk_pin <= (n == 8'h05);
      #1;
    end
    chk("power-up cycles", 8'h1E, n);
    chk("register after delay", 8'h00, reg_state);
    pulse(8'hFF);
    chk("capture all", 8'hFF, reg_state);
    chk("pins after capture", 8'h00, io_out);
    chk("registered enables", 8'hFF, io_oe);
    pulse(8'h10);
    chk("capture feedback", 8'h73, reg_state);
    chk("pins inverted", 8'h8C, io_out);
    @(posedge clk_sys);
    oe_n_pin <= 1'b1;
    #1;
    chk("enable pin off", 8'h00, io_oe);
    @(posedge clk_sys);
    cfg_mode <= pmc_pkg::MODE_COMPLEX;
    pulse(8'hFF);
    chk("no capture in complex", 8'h73, reg_state);
    // inverted cell 1 must reach cell 6 through the neighbour feedback
    @(posedge clk_sys);
    set_cfg(2'h2, 16'h5555);
    cfg_polarity <= 8'h02;
    in_pin <= 8'h00;
    @(posedge clk_sys);
    #1;
    chk("inverted neighbour", 8'h62, io_out);
    chk("simple enables", 8'hFF, io_oe);
    test_done();
  end
endmodule
`default_nettype wire

// [src/pmc_and_array.sv]
// programmable and-array producing all product terms
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"

module pmc_and_array (
  input wire logic [`PMC_ARRAY_W-1:0] array_in,
  input wire logic [`PMC_NUM_PT-1:0][`PMC_LIT_W-1:0] and_fuse,
  input wire logic [`PMC_NUM_PT-1:0] pt_en,
  output logic [`PMC_NUM_PT-1:0] pt
);

  // ****************************************
  // literals and product terms
  // ****************************************
  // true literals low half, complements high half
  wire logic [`PMC_LIT_W-1:0] lit;
  assign lit = {~array_in, array_in};

  // a set fuse connects its literal; disabled terms stay low
  genvar p;
  generate
    for (p = 0; p < `PMC_NUM_PT; p = p + 1) begin : g_pt
      assign pt[p] = pt_en[p] & (&(lit | ~and_fuse[p]));
    end
  endgenerate

endmodule
`default_nettype wire

// [src/pmc_cell.sv]
// one output logic cell: sum term, register, enable and pin drive
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"

module pmc_cell #(
  parameter bit IS_OUTER = 1'b0,
  parameter bit IS_INNER = 1'b0
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pmc_pkg::pmc_mode_type mode,
  input wire pmc_pkg::pmc_kind_type kind,
  input wire logic polarity,
  input wire logic [`PMC_PT_PER_CELL-1:0] pt,
  input wire logic clk_rise,
  input wire logic por_busy,
  input wire logic oe_n_pin,
  output logic pin_out,
  output logic pin_oe,
  output logic reg_q
);

  // ****************************************
  // kind decode
  // ****************************************
  // register only exists in registered mode
  function automatic logic is_reg(input pmc_pkg::pmc_mode_type m,
                                  input pmc_pkg::pmc_kind_type k);
    is_reg = (m == pmc_pkg::MODE_REGISTERED) && (k == pmc_pkg::KIND_REG);
  endfunction

  wire logic use_reg;
  wire logic as_input;
  wire logic sum8;
  wire logic sum7;
  wire logic comb_val;
  logic reg_ff;
  logic nxt_reg;

  assign use_reg = is_reg(mode, kind);
  // outer cells in complex mode and inner cells in simple mode cannot be inputs
  assign as_input = (kind == pmc_pkg::KIND_INPUT) &&
                    !(IS_OUTER && mode == pmc_pkg::MODE_COMPLEX) &&
                    !(IS_INNER && mode == pmc_pkg::MODE_SIMPLE);

  // ****************************************
  // sum terms
  // ****************************************
  assign sum8 = |pt;
  assign sum7 = |pt[`PMC_PT_PER_CELL-1:1];
  assign comb_val = ((mode == pmc_pkg::MODE_SIMPLE) ? sum8 : sum7) ^ polarity;

  // ****************************************
  // cell register
  // ****************************************
  // held low until power-up delay ends, then clocked by clock pin rise
  always_comb begin
    nxt_reg = reg_ff;
    if (por_busy) begin
      nxt_reg = 1'b0;
    end else if (use_reg && clk_rise) begin
      nxt_reg = sum8;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      reg_ff <= 1'b0;
    end else begin
      reg_ff <= nxt_reg;
    end
  end

  assign reg_q = reg_ff;

  // ****************************************
  // pin drive and enable
  // ****************************************
  assign pin_out = use_reg ? ~reg_ff : comb_val;

  always_comb begin
    pin_oe = 1'b0;
    case (mode)
      pmc_pkg::MODE_REGISTERED: begin
        if (as_input) begin
          pin_oe = 1'b0;
        end else if (use_reg) begin
          pin_oe = ~oe_n_pin;
        end else begin
          pin_oe = pt[`PMC_OE_PT];
        end
      end
      pmc_pkg::MODE_COMPLEX: begin
        pin_oe = as_input ? 1'b0 : pt[`PMC_OE_PT];
      end
      pmc_pkg::MODE_SIMPLE: begin
        pin_oe = IS_INNER ? 1'b1 : !as_input;
      end
      default: begin
        pin_oe = 1'b0;
      end
    endcase
  end

endmodule
`default_nettype wire

// [src/pmc_defs.svh]
// constants for the configurable output cell fabric
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// ****************************************
// fabric dimensions
// ****************************************
`define PMC_NUM_CELLS 8
`define PMC_NUM_IN 8
`define PMC_PT_PER_CELL 8
`define PMC_NUM_PT 64
`define PMC_ARRAY_W 16
`define PMC_LIT_W 32

// ****************************************
// cell positions and product term roles
// ****************************************
`define PMC_OUTER_LO 0
`define PMC_OUTER_HI 7
`define PMC_INNER_LO 3
`define PMC_INNER_HI 4
`define PMC_OE_PT 0
`define PMC_FB_BASE 8

// ****************************************
// power-up reset timing
// ****************************************
`define PMC_CLK_PERIOD_NS 20
`define PMC_T_PR_NS 600
`define PMC_POR_CYCLES ((`PMC_T_PR_NS + `PMC_CLK_PERIOD_NS - 1) / `PMC_CLK_PERIOD_NS)
`define PMC_POR_CNT_W 5

`endif

// [src/pmc_pkg.sv]
// types shared by the cell fabric modules
`default_nettype none
package pmc_pkg;

  // ****************************************
  // architecture modes and cell kinds
  // ****************************************
  typedef enum logic [1:0] {MODE_REGISTERED, MODE_COMPLEX, MODE_SIMPLE} pmc_mode_type;
  typedef enum logic [1:0] {KIND_REG, KIND_COMB, KIND_INPUT} pmc_kind_type;
  typedef enum logic {POR_WAIT, POR_RUN} pmc_por_type;

endpackage
`default_nettype wire

// [src/pmc_top.sv]
// fabric top: mode decode, feedback routing, clock pin and power-up reset
`timescale 1ns/1ns
`default_nettype none
`include "pmc_defs.svh"

// Function
// - registered mode: clock and enable pins dedicated
// - complex mode: clock, enable pins enter array
// - complex mode: outer cells output only
// - simple mode: feedback comes from neighbour pin
// - simple mode: inner cells always driven, no feedback
// - registered mode: cell is register, comb or input
// - register clocked by clock pin, enabled by pin
// - registered cell sums eight product terms
// - comb cell: one enable term, seven summed
// - input cell never drives its pin
// - complex mode: six inner cells feed pin back
// - complex mode: seven summed, one enable term
// - simple mode: eight summed, clock/enable are inputs
// - simple mode: others input or comb output
// - power-up: registers held clear during short delay
module pmc_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire pmc_pkg::pmc_mode_type cfg_mode,
  input wire pmc_pkg::pmc_kind_type [`PMC_NUM_CELLS-1:0] cfg_kind,
  input wire logic [`PMC_NUM_CELLS-1:0] cfg_polarity,
  input wire logic [`PMC_NUM_PT-1:0] cfg_pt_en,
  input wire logic [`PMC_NUM_PT-1:0][`PMC_LIT_W-1:0] cfg_and_fuse,
  input wire logic clk_pin,
  input wire logic oe_n_pin,
  input wire logic [`PMC_NUM_IN-1:0] in_pin,
  input wire logic [`PMC_NUM_CELLS-1:0] io_in,
  output logic [`PMC_NUM_CELLS-1:0] io_out,
  output logic [`PMC_NUM_CELLS-1:0] io_oe,
  output logic [`PMC_NUM_CELLS-1:0] reg_state,
  output logic por_done
);

  // ****************************************
  // mode decode
  // ****************************************
  wire logic mode_reg;
  wire logic mode_cplx;
  wire logic mode_simple;

  assign mode_reg = (cfg_mode == pmc_pkg::MODE_REGISTERED);
  assign mode_cplx = (cfg_mode == pmc_pkg::MODE_COMPLEX);
  assign mode_simple = (cfg_mode == pmc_pkg::MODE_SIMPLE);

  // ****************************************
  // power-up reset sequencer
  // ****************************************
  pmc_pkg::pmc_por_type por_state_ff;
  pmc_pkg::pmc_por_type nxt_por_state;
  logic [`PMC_POR_CNT_W-1:0] por_cnt_ff;
  logic [`PMC_POR_CNT_W-1:0] nxt_por_cnt;
  wire logic por_busy;
  wire logic por_last;

  assign por_last = (por_cnt_ff == `PMC_POR_CNT_W'(`PMC_POR_CYCLES - 1));

  // count the delay after reset release before registers may clock
  always_comb begin
    nxt_por_state = por_state_ff;
    nxt_por_cnt = por_cnt_ff;
    case (por_state_ff)
      pmc_pkg::POR_WAIT: begin
        if (por_last) begin
          nxt_por_state = pmc_pkg::POR_RUN;
        end else begin
          nxt_por_cnt = por_cnt_ff + `PMC_POR_CNT_W'(1);
        end
      end
      pmc_pkg::POR_RUN: begin
        nxt_por_state = pmc_pkg::POR_RUN;
      end
      default: begin
        nxt_por_state = pmc_pkg::POR_WAIT;
        nxt_por_cnt = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      por_state_ff <= pmc_pkg::POR_WAIT;
      por_cnt_ff <= '0;
    end else begin
      por_state_ff <= nxt_por_state;
      por_cnt_ff <= nxt_por_cnt;
    end
  end

  assign por_busy = (por_state_ff != pmc_pkg::POR_RUN);
  assign por_done = !por_busy;

  // ****************************************
  // clock pin edge detect
  // ****************************************
  logic clk_pin_ff;
  wire logic clk_rise;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      clk_pin_ff <= 1'b0;
    end else begin
      clk_pin_ff <= clk_pin;
    end
  end

  // clock pin acts as register clock only in registered mode
  assign clk_rise = mode_reg & clk_pin & ~clk_pin_ff;

  // ****************************************
  // feedback routing into the array
  // ****************************************
  wire logic [`PMC_NUM_CELLS-1:0] fb_slot;
  wire logic [`PMC_NUM_CELLS-1:0] reg_q;
  wire logic [`PMC_ARRAY_W-1:0] array_in;

  genvar s;
  generate
    for (s = 0; s < `PMC_NUM_CELLS; s = s + 1) begin : g_fb
      // registered mode: register state or own pin
      wire logic fb_regmode;
      // complex mode: outer slots borrowed by clock and enable pins
      wire logic fb_cplx;
      // simple mode: neighbour pin, outer slots carry clock/enable pins
      wire logic fb_simple;

      assign fb_regmode = (cfg_kind[s] == pmc_pkg::KIND_REG) ? reg_q[s] : io_in[s];

      if (s == `PMC_OUTER_LO) begin : g_lo
        assign fb_cplx = clk_pin;
        assign fb_simple = clk_pin;
      end else if (s == `PMC_OUTER_HI) begin : g_hi
        assign fb_cplx = oe_n_pin;
        assign fb_simple = oe_n_pin;
      end else if (s <= `PMC_INNER_LO) begin : g_low_half
        assign fb_cplx = io_in[s];
        assign fb_simple = io_in[s-1];
      end else begin : g_high_half
        assign fb_cplx = io_in[s];
        assign fb_simple = io_in[s+1];
      end

      // slot source for the active mode; an unused mode code reads low
      assign fb_slot[s] = mode_reg ? fb_regmode :
                          mode_cplx ? fb_cplx :
                          mode_simple ? fb_simple : 1'b0;
    end
  endgenerate

  assign array_in = {fb_slot, in_pin};

  // ****************************************
  // and-array
  // ****************************************
  wire logic [`PMC_NUM_PT-1:0] pt;

  pmc_and_array u_and_array (
    .array_in(array_in),
    .and_fuse(cfg_and_fuse),
    .pt_en(cfg_pt_en),
    .pt(pt)
  );

  // ****************************************
  // output logic cells
  // ****************************************
  genvar c;
  generate
    for (c = 0; c < `PMC_NUM_CELLS; c = c + 1) begin : g_cell
      pmc_cell #(
        .IS_OUTER((c == `PMC_OUTER_LO) || (c == `PMC_OUTER_HI)),
        .IS_INNER((c == `PMC_INNER_LO) || (c == `PMC_INNER_HI))
      ) u_cell (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .mode(cfg_mode),
        .kind(cfg_kind[c]),
        .polarity(cfg_polarity[c]),
        .pt(pt[c*`PMC_PT_PER_CELL +: `PMC_PT_PER_CELL]),
        .clk_rise(clk_rise),
        .por_busy(por_busy),
        .oe_n_pin(oe_n_pin),
        .pin_out(io_out[c]),
        .pin_oe(io_oe[c]),
        .reg_q(reg_q[c])
      );
    end
  endgenerate

  // register state visible for test checks
  assign reg_state = reg_q;

endmodule
`default_nettype wire
